// ==== logic/lane_cfg_defs.vh ====
// constants and bit layout of the lane configuration registers
// Operation
// - bits 15:12 of each lane register read zero and ignore writes
// - bit 11 clock tolerance enable, reset 0, ORed with global bit 11
// - bits 10:9 pick lane A status pin: hstl, comma, lost, pass
// - lane B status pin same, using lost bit 1 and pass bit 5
// - effective status select is lane bits 10:9 OR global bits 10:9
// - bit 8 signal lost detection, reset 1, ANDed with global bit 8
// - bit 7 config one, reset 0, settable only while its pin low, ORed
// - bit 6 config zero, reset 0, settable only while its pin low, ORed
// - bits 5 and 4 preemphasis, reset 0, ORed with global bits 5 and 4
// - bit 3 loopback, reset 0, ORed with control register bit 14
// - lane A loopback settable only while loopback pin is low
// - bit 2 pattern test enable, reset 0, ORed with global bit 2
// - pattern bit settable only while pattern pin low; pin ORed in
// - bit 1 alignment enable, reset 1, ANDed with sync pin and global
// - bit 0 power down, reset 0, ORed with control register bit 11
// - a global register write overwrites lane register bits 11:4, 2 and 1, not loopback bit 3 or power down bit 0
`ifndef LANE_CFG_DEFS_VH
`define LANE_CFG_DEFS_VH

// ----------------------------------------------------------------
// register indexes, byte address is four times the index
// ----------------------------------------------------------------
`define LANE_A_CONFIG_IDX 6'h11
`define LANE_B_CONFIG_IDX 6'h12
`define ADR_IDX_HI 7
`define ADR_IDX_LO 2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define F_RSV_HI 15
`define F_RSV_LO 12
`define F_CTC 11
`define F_SEL_HI 10
`define F_SEL_LO 9
`define F_LOS 8
`define F_CFG1 7
`define F_CFG0 6
`define F_PRE_TWO 5
`define F_PRE_ONE 4
`define F_LOOP 3
`define F_PRBS 2
`define F_ALIGN 1
`define F_PDN 0
`define F_CTL_LOOP 14
`define F_CTL_PDN 11

// ----------------------------------------------------------------
// reset value, writable mask, global overwrite mask
// ----------------------------------------------------------------
`define LANE_RESET 16'h0102
`define LANE_WMASK 16'h0FFF
`define GLB_MASK 16'h0FF6

// ----------------------------------------------------------------
// status pin select codes and status register 22 bit positions
// ----------------------------------------------------------------
`define SEL_HSTL 2'h0
`define SEL_COMMA 2'h1
`define SEL_LOST 2'h2
`define SEL_PASS 2'h3
`define LOST_A_BIT 0
`define LOST_B_BIT 1
`define PASS_A_BIT 4
`define PASS_B_BIT 5

`endif

// ==== logic/lane_cfg_regs.v ====
// per-lane configuration registers for lanes a and b, wishbone slave
`default_nettype none
`include "lane_cfg_defs.vh"

module lane_cfg_regs (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // global configuration and control register bits
    input wire [15:0] glb_cfg_i,
    input wire glb_wr_i,
    input wire [15:0] ctl_reg_i,
    // device pins
    input wire config_one_pin,
    input wire config_zero_pin,
    input wire loopback_a_pin,
    input wire pattern_test_pin,
    input wire sync_enable_pin,
    input wire hstl_pin_i,
    // status from lane logic
    input wire [1:0] comma_det_i,
    input wire [7:0] status_reg_i,
    // effective lane controls, bit 0 lane a, bit 1 lane b
    output reg [1:0] ctc_en_o,
    output reg [1:0] los_det_en_o,
    output reg [1:0] config_bit_one_o,
    output reg [1:0] config_bit_zero_o,
    output reg [1:0] pre_two_o,
    output reg [1:0] pre_one_o,
    output reg [1:0] loopback_o,
    output reg [1:0] pattern_en_o,
    output reg [1:0] align_en_o,
    output reg [1:0] power_down_o,
    // status pins
    output reg lane_a_status_pin_o,
    output reg lane_b_status_pin_o
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // write into a lane register with pin locks on settable bits
    function [15:0] lane_write;
        input [15:0] old;
        input [15:0] wdata;
        input [15:0] wmask;
        input lock_cfg1;
        input lock_cfg0;
        input lock_loop;
        input lock_prbs;
        reg [15:0] m;
        begin
            m = wmask & `LANE_WMASK;
            if (lock_cfg1) begin
                m[`F_CFG1] = 1'b0;
            end
            if (lock_cfg0) begin
                m[`F_CFG0] = 1'b0;
            end
            if (lock_loop) begin
                m[`F_LOOP] = 1'b0;
            end
            if (lock_prbs) begin
                m[`F_PRBS] = 1'b0;
            end
            lane_write = (old & ~m) | (wdata & m);
        end
    endfunction

    // status pin source for one lane
    function status_pick;
        input [1:0] code;
        input hstl;
        input comma;
        input lost;
        input pass;
        begin
            case (code)
                `SEL_HSTL: status_pick = hstl;
                `SEL_COMMA: status_pick = comma;
                `SEL_LOST: status_pick = lost;
                `SEL_PASS: status_pick = pass;
                default: status_pick = hstl;
            endcase
        end
    endfunction

    // register index match for a byte address
    function reg_hit;
        input [7:0] adr;
        input [5:0] index;
        begin
            reg_hit = (adr[`ADR_IDX_HI:`ADR_IDX_LO] == index);
        end
    endfunction

    // read view of a lane register, reserved bits as zero
    function [31:0] lane_read;
        input [15:0] word;
        begin
            lane_read = {16'h0000, word & `LANE_WMASK};
        end
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    reg cfg1_meta_q;
    reg cfg0_meta_q;
    reg loop_meta_q;
    reg prbs_meta_q;
    reg sync_meta_q;
    reg hstl_meta_q;
    reg cfg1_sync_q;
    reg cfg0_sync_q;
    reg loop_sync_q;
    reg prbs_sync_q;
    reg sync_sync_q;
    reg hstl_sync_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg1_meta_q <= 1'b0;
            cfg0_meta_q <= 1'b0;
            loop_meta_q <= 1'b0;
            prbs_meta_q <= 1'b0;
            sync_meta_q <= 1'b0;
            hstl_meta_q <= 1'b0;
            cfg1_sync_q <= 1'b0;
            cfg0_sync_q <= 1'b0;
            loop_sync_q <= 1'b0;
            prbs_sync_q <= 1'b0;
            sync_sync_q <= 1'b0;
            hstl_sync_q <= 1'b0;
        end else begin
            cfg1_meta_q <= config_one_pin;
            cfg0_meta_q <= config_zero_pin;
            loop_meta_q <= loopback_a_pin;
            prbs_meta_q <= pattern_test_pin;
            sync_meta_q <= sync_enable_pin;
            hstl_meta_q <= hstl_pin_i;
            cfg1_sync_q <= cfg1_meta_q;
            cfg0_sync_q <= cfg0_meta_q;
            loop_sync_q <= loop_meta_q;
            prbs_sync_q <= prbs_meta_q;
            sync_sync_q <= sync_meta_q;
            hstl_sync_q <= hstl_meta_q;
        end
    end

    wire cfg1_pin_s;
    wire cfg0_pin_s;
    wire loop_pin_s;
    wire prbs_pin_s;
    wire sync_pin_s;
    wire hstl_pin_s;

    assign cfg1_pin_s = cfg1_sync_q;
    assign cfg0_pin_s = cfg0_sync_q;
    assign loop_pin_s = loop_sync_q;
    assign prbs_pin_s = prbs_sync_q;
    assign sync_pin_s = sync_sync_q;
    assign hstl_pin_s = hstl_sync_q;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    reg ack_q;
    wire hit_a;
    wire hit_b;
    wire do_write;
    wire [15:0] bus_mask;

    assign hit_a = reg_hit(adr_i, `LANE_A_CONFIG_IDX);
    assign hit_b = reg_hit(adr_i, `LANE_B_CONFIG_IDX);
    assign do_write = cyc_i & stb_i & we_i & ack_q;
    assign bus_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

    // ----------------------------------------------------------------
    // lane registers
    // ----------------------------------------------------------------
    reg [15:0] lane_a_config_q;
    reg [15:0] lane_b_config_q;
    reg [15:0] lane_a_config_d;
    reg [15:0] lane_b_config_d;

    always @* begin
        lane_a_config_d = lane_a_config_q;
        lane_b_config_d = lane_b_config_q;
        if (glb_wr_i) begin
            lane_a_config_d = lane_write(lane_a_config_d, glb_cfg_i,
                `GLB_MASK, cfg1_pin_s, cfg0_pin_s, loop_pin_s,
                prbs_pin_s);
            lane_b_config_d = lane_write(lane_b_config_d, glb_cfg_i,
                `GLB_MASK, cfg1_pin_s, cfg0_pin_s, 1'b0,
                prbs_pin_s);
        end
        if (do_write && hit_a) begin
            lane_a_config_d = lane_write(lane_a_config_d, dat_i[15:0],
                bus_mask, cfg1_pin_s, cfg0_pin_s, loop_pin_s,
                prbs_pin_s);
        end
        if (do_write && hit_b) begin
            lane_b_config_d = lane_write(lane_b_config_d, dat_i[15:0],
                bus_mask, cfg1_pin_s, cfg0_pin_s, 1'b0, prbs_pin_s);
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            lane_a_config_q <= `LANE_RESET;
            lane_b_config_q <= `LANE_RESET;
        end else begin
            lane_a_config_q <= lane_a_config_d;
            lane_b_config_q <= lane_b_config_d;
        end
    end

    // ----------------------------------------------------------------
    // bus answer
    // ----------------------------------------------------------------
    reg [31:0] rd_data;

    always @* begin
        rd_data = 32'h0000_0000;
        if (hit_a) begin
            rd_data = lane_read(lane_a_config_q);
        end else if (hit_b) begin
            rd_data = lane_read(lane_b_config_q);
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_q <= cyc_i & stb_i & ~ack_q;
            ack_o <= cyc_i & stb_i & ~ack_q;
            dat_o <= rd_data;
        end
    end

    // ----------------------------------------------------------------
    // effective controls
    // ----------------------------------------------------------------
    reg [15:0] lane_q [0:1];
    integer i;
    reg [1:0] sel_code;
    reg [1:0] ctc_d;
    reg [1:0] los_d;
    reg [1:0] cfg1_d;
    reg [1:0] cfg0_d;
    reg [1:0] pre_two_d;
    reg [1:0] pre_one_d;
    reg [1:0] loop_d;
    reg [1:0] prbs_d;
    reg [1:0] align_d;
    reg [1:0] pdn_d;
    reg [1:0] stat_d;

    always @* begin
        lane_q[0] = lane_a_config_q;
        lane_q[1] = lane_b_config_q;
        sel_code = 2'h0;
        ctc_d = 2'h0;
        los_d = 2'h0;
        cfg1_d = 2'h0;
        cfg0_d = 2'h0;
        pre_two_d = 2'h0;
        pre_one_d = 2'h0;
        loop_d = 2'h0;
        prbs_d = 2'h0;
        align_d = 2'h0;
        pdn_d = 2'h0;
        stat_d = 2'h0;
        for (i = 0; i < 2; i = i + 1) begin
            ctc_d[i] = lane_q[i][`F_CTC] | glb_cfg_i[`F_CTC];
            los_d[i] = lane_q[i][`F_LOS] & glb_cfg_i[`F_LOS];
            cfg1_d[i] = lane_q[i][`F_CFG1] | glb_cfg_i[`F_CFG1];
            cfg0_d[i] = lane_q[i][`F_CFG0] | glb_cfg_i[`F_CFG0];
            pre_two_d[i] = lane_q[i][`F_PRE_TWO] | glb_cfg_i[`F_PRE_TWO];
            pre_one_d[i] = lane_q[i][`F_PRE_ONE] | glb_cfg_i[`F_PRE_ONE];
            loop_d[i] = lane_q[i][`F_LOOP] | ctl_reg_i[`F_CTL_LOOP];
            prbs_d[i] = lane_q[i][`F_PRBS] | glb_cfg_i[`F_PRBS]
                | prbs_pin_s;
            align_d[i] = lane_q[i][`F_ALIGN] & sync_pin_s
                & glb_cfg_i[`F_ALIGN];
            pdn_d[i] = lane_q[i][`F_PDN] | ctl_reg_i[`F_CTL_PDN];
            sel_code = lane_q[i][`F_SEL_HI:`F_SEL_LO]
                | glb_cfg_i[`F_SEL_HI:`F_SEL_LO];
            if (i == 0) begin
                stat_d[i] = status_pick(sel_code, hstl_pin_s,
                    comma_det_i[i], status_reg_i[`LOST_A_BIT],
                    status_reg_i[`PASS_A_BIT]);
            end else begin
                stat_d[i] = status_pick(sel_code, hstl_pin_s,
                    comma_det_i[i], status_reg_i[`LOST_B_BIT],
                    status_reg_i[`PASS_B_BIT]);
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ctc_en_o <= 2'h0;
            los_det_en_o <= 2'h0;
            config_bit_one_o <= 2'h0;
            config_bit_zero_o <= 2'h0;
            pre_two_o <= 2'h0;
            pre_one_o <= 2'h0;
            loopback_o <= 2'h0;
            pattern_en_o <= 2'h0;
            align_en_o <= 2'h0;
            power_down_o <= 2'h0;
            lane_a_status_pin_o <= 1'b0;
            lane_b_status_pin_o <= 1'b0;
        end else begin
            ctc_en_o <= ctc_d;
            los_det_en_o <= los_d;
            config_bit_one_o <= cfg1_d;
            config_bit_zero_o <= cfg0_d;
            pre_two_o <= pre_two_d;
            pre_one_o <= pre_one_d;
            loopback_o <= loop_d;
            pattern_en_o <= prbs_d;
            align_en_o <= align_d;
            power_down_o <= pdn_d;
            lane_a_status_pin_o <= stat_d[0];
            lane_b_status_pin_o <= stat_d[1];
        end
    end

endmodule
`default_nettype wire

// ==== sim/lane_cfg_regs_asserts.sv ====
// assertion checker for the lane configuration register block
`default_nettype none
module lane_cfg_regs_asserts (
    // clock, reset and bus
    input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
    input wire logic [31:0] dat_o,
    // global, control and status inputs
    input wire logic glb_wr_i,
    input wire logic [15:0] glb_cfg_i, ctl_reg_i,
    input wire logic [7:0] status_reg_i,
    // effective controls and status pins
    input wire logic [1:0] ctc_en_o, los_det_en_o, loopback_o,
    input wire logic [1:0] align_en_o, power_down_o,
    input wire logic lane_a_status_pin_o, lane_b_status_pin_o
);
    // ------------------------------------------------------------
    // settle counter after reset
    // ------------------------------------------------------------
    logic [1:0] run_q;
    wire logic live;
    assign live = run_q == 2'h3;
    always_ff @(posedge clk_i) begin
        if (rst_i)
            run_q <= 2'h0;
        else if (run_q != 2'h3)
            run_q <= run_q + 2'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_after_req: assert property ($rose(cyc_i && stb_i) |=> ack_o)
        else $error("ack did not follow request");
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (ack_o |-> cyc_i && stb_i)
        else $error("ack without request");
    a_rsv_read_zero: assert property (
        ack_o && !we_i |-> dat_o[31:12] == 20'h00000)
        else $error("upper read bits not zero");
    a_ctc_or_glb: assert property (
        live && $past(glb_cfg_i[11]) |-> ctc_en_o == 2'h3)
        else $error("clock tolerance not forced");
    a_los_and_glb: assert property (
        live && !$past(glb_cfg_i[8]) |-> los_det_en_o == 2'h0)
        else $error("signal lost detection not masked");
    a_align_and_glb: assert property (
        live && !$past(glb_cfg_i[1]) |-> align_en_o == 2'h0)
        else $error("alignment not masked");
    a_loop_or_ctl: assert property (
        live && $past(ctl_reg_i[14]) |-> loopback_o == 2'h3)
        else $error("loopback not forced");
    a_pdn_or_ctl: assert property (
        live && $past(ctl_reg_i[11]) |-> power_down_o == 2'h3)
        else $error("power down not forced");
    a_sel_pass_bits: assert property (
        live && $past(glb_cfg_i[10:9]) == 2'h3
        |-> lane_a_status_pin_o == $past(status_reg_i[4])
        && lane_b_status_pin_o == $past(status_reg_i[5]))
        else $error("status pin not pass bit");
    c_write: cover property (ack_o && we_i);
    c_read: cover property (ack_o && !we_i);
    c_glb_write: cover property (glb_wr_i);
endmodule
bind lane_cfg_regs lane_cfg_regs_asserts chk (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .ack_o, .dat_o, .glb_wr_i, .glb_cfg_i, .ctl_reg_i,
    .status_reg_i, .ctc_en_o, .los_det_en_o, .loopback_o, .align_en_o,
    .power_down_o, .lane_a_status_pin_o, .lane_b_status_pin_o);
`default_nettype wire

// ==== sim/per_lane_config_registers_bench.sv ====
// self-checking bench for the lane configuration register block
`default_nettype none
module per_lane_config_registers_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic glb_wr_i = 0, hstl_pin_i = 0, sync_enable_pin = 1;
    logic config_one_pin = 0, config_zero_pin = 0;
    logic loopback_a_pin = 0, pattern_test_pin = 0;
    logic [7:0] adr_i = 8'h00, status_reg_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [15:0] glb_cfg_i = 16'h0102, ctl_reg_i = 16'h0000;
    logic [1:0] comma_det_i = 2'h0;
    logic [1:0] ctc_en_o, los_det_en_o, config_bit_one_o, config_bit_zero_o;
    logic [1:0] pre_two_o, pre_one_o, loopback_o, pattern_en_o;
    logic [1:0] align_en_o, power_down_o, sel_exp [4];
    logic ack_o, lane_a_status_pin_o, lane_b_status_pin_o;
    logic [19:0] eff;
    int fail_count = 0, tests_run = 0;
    typedef struct {
        logic [7:0] a;
        logic [15:0] w, r;
        logic [19:0] e;
    } row_t;
    row_t rows [5] = '{'{8'h44, 16'hFFFF, 16'h0FFF, 20'h7555D},
        '{8'h48, 16'hF0A5, 16'h00A5, 20'h5DD77},
        '{8'h40, 16'h1234, 16'h0000, 20'h5DD77},
        '{8'h44, 16'h0000, 16'h0000, 20'h08822},
        '{8'h48, 16'h0102, 16'h0102, 20'h20008}};
    assign eff = {ctc_en_o, los_det_en_o, config_bit_one_o,
        config_bit_zero_o, pre_two_o, pre_one_o, loopback_o, pattern_en_o,
        align_en_o, power_down_o};
    lane_cfg_regs dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o, .glb_cfg_i, .glb_wr_i, .ctl_reg_i,
        .config_one_pin, .config_zero_pin, .loopback_a_pin,
        .pattern_test_pin, .sync_enable_pin, .hstl_pin_i, .comma_det_i,
        .status_reg_i, .ctc_en_o, .los_det_en_o, .config_bit_one_o,
        .config_bit_zero_o, .pre_two_o, .pre_one_o, .loopback_o,
        .pattern_en_o, .align_en_o, .power_down_o, .lane_a_status_pin_o,
        .lane_b_status_pin_o);
    always #20 clk_i = ~clk_i;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            fail_count++;
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [15:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h3;
        dat_i <= {16'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20)
            fail_count++;
        r = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sel_exp = '{2'h3, 2'h2, 2'h1, 2'h1};
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        wb(0, 8'h48, 16'h0, rd);
        check(rd, 32'h0102);
        check({12'h0, eff}, 32'h3000C);
        foreach (rows[i]) begin
            wb(1, rows[i].a, rows[i].w, rd);
            wb(0, rows[i].a, 16'h0, rd);
            check(rd, {16'h0, rows[i].r});
            check({12'h0, eff}, {12'h0, rows[i].e});
        end
        glb_cfg_i <= 16'h08F4;
        ctl_reg_i <= 16'h4800;
        repeat (3) @(posedge clk_i);
        check({12'h0, eff}, 32'hCFFF3);
        glb_cfg_i <= 16'h0102;
        ctl_reg_i <= 16'h0000;
        pattern_test_pin <= 1;
        config_one_pin <= 1;
        config_zero_pin <= 1;
        loopback_a_pin <= 1;
        sync_enable_pin <= 0;
        repeat (5) @(posedge clk_i);
        check({30'h0, pattern_en_o}, 32'h3);
        check({30'h0, align_en_o}, 32'h0);
        wb(1, 8'h44, 16'h00CC, rd);
        wb(0, 8'h44, 16'h0, rd);
        check(rd, 32'h0000);
        wb(1, 8'h48, 16'h00CC, rd);
        wb(0, 8'h48, 16'h0, rd);
        check(rd, 32'h0008);
        {pattern_test_pin, config_one_pin, config_zero_pin} <= 3'h0;
        loopback_a_pin <= 0;
        sync_enable_pin <= 1;
        hstl_pin_i <= 1;
        comma_det_i <= 2'h1;
        status_reg_i <= 8'h22;
        for (int c = 0; c < 4; c++) begin
            glb_cfg_i <= {5'h0, c[1:0], 9'h102};
            repeat (5) @(posedge clk_i);
            check({30'h0, lane_a_status_pin_o, lane_b_status_pin_o},
                {30'h0, sel_exp[c]});
        end
        glb_cfg_i <= 16'h0302;
        wb(1, 8'h44, 16'h0400, rd);
        repeat (2) @(posedge clk_i);
        check({30'h0, lane_a_status_pin_o, lane_b_status_pin_o},
            32'h0);
        glb_cfg_i <= 16'h0FF6;
        glb_wr_i <= 1;
        @(posedge clk_i);
        glb_wr_i <= 0;
        wb(0, 8'h44, 16'h0, rd);
        check(rd, 32'h0FF6);
        wb(0, 8'h48, 16'h0, rd);
        check(rd, 32'h0FFE);
        rst_i <= 1;
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        wb(0, 8'h44, 16'h0, rd);
        check(rd, 32'h0102);
        end_of_test();
    end
endmodule
`default_nettype wire
